// [inc/fpc_pkg.sv]
// Purpose: Shared constants for the protection command handler and its host end
// Assumes: SPI mode 0, instruction byte MSB first, CLK at 20 MHz
// Notes:   Device and host both import nothing; every use is scoped
package fpc_pkg;
   // Instruction codes
   localparam logic [7:0] CMD_CFG_READ   = 8'h2b;
   localparam logic [7:0] CMD_CFG_PROG   = 8'h2f;
   localparam logic [7:0] CMD_LOCK_READ  = 8'ha7;
   localparam logic [7:0] CMD_LOCK_FRZ   = 8'ha6;
   localparam logic [7:0] CMD_PW_READ    = 8'he7;
   localparam logic [7:0] CMD_PW_PROG    = 8'he8;
   localparam logic [7:0] CMD_PW_UNLOCK  = 8'hea;
   localparam logic [7:0] CMD_WRITE_ENABLE_CMD       = 8'h06;
   localparam logic [7:0] CMD_CLR_STAT   = 8'h30;
   localparam logic [7:0] CMD_RST_ARM    = 8'h66;
   localparam logic [7:0] CMD_RST_GO     = 8'h99;
   localparam logic [7:0] CMD_STAT_READ  = 8'h05;
   // Register widths and field positions
   localparam int CFG_W          = 16;
   localparam int LOCK_W         = 8;
   localparam int PW_W           = 64;
   localparam int LOCK_VOL_BIT   = 0;
   localparam int LOCK_SECR_BIT  = 6;
   localparam int CFG_SECR_BIT   = 6;
   localparam int CFG_PWMODE_BIT = 2;
   localparam int STAT_WIP_BIT   = 0;
   localparam int STAT_WEL_BIT   = 1;
   localparam int STAT_PERR_BIT  = 5;
   // Reset values of the non-volatile store (erased state)
   localparam logic [15:0] CFG_RST  = 16'hffff;
   localparam logic [7:0]  LOCK_RST = 8'h41;
   localparam logic [63:0] PW_RST   = 64'hffff_ffff_ffff_ffff;
   // Self-timed write duration
   localparam int T_WRITE_US   = 50;
   localparam int CLK_MHZ      = 20;
   localparam int WRITE_CYCLES = T_WRITE_US * CLK_MHZ;
   // Host SCK divider: half period in CLK cycles
   localparam int SCK_HALF     = 4;
   localparam int LAT_CYCLES   = 1;
endpackage

// [inc/fpc_if.sv]
// Purpose: SPI link between host controller and protection command handler
// Assumes: Four data lines, each two signals per end
// Notes:   Wire level is resolved here from enables; undriven lines read high
interface fpc_if;
   logic       cs_n;
   logic       sck;
   logic [3:0] h_do;
   logic [3:0] h_oe;
   logic [3:0] d_do;
   logic [3:0] d_oe;
   logic [3:0] io;
   // Pull-up on every line when nobody drives it
   assign io = (h_oe & h_do) | (d_oe & d_do) | ~(h_oe | d_oe);
   modport dev  (input cs_n, input sck, input io, output d_do, output d_oe);
   modport host (output cs_n, output sck, output h_do, output h_oe, input io);
endinterface

// [design/fpc_sync.sv]
// Purpose: Two-flop synchroniser for link pins
// Assumes: Destination clock CLK
// Notes:   First stage feeds only the second stage
module fpc_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input  wire logic         CLK,
   input  wire logic         RSTN,
   input  wire logic [W-1:0] D,
   output logic      [W-1:0] Q
);
   logic [W-1:0] meta_r;
   // Two stages against metastability
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         meta_r <= INIT;
         Q      <= INIT;
      end else begin
         meta_r <= D;
         Q      <= meta_r;
      end
   end
endmodule

// [design/fpc_dev.sv]
// Purpose: Protection register and password command handler of a serial flash
// Assumes: SPI mode 0; SCK sampled by CLK, so SCK must be well below CLK/4
// Notes:   Self-timed writes take WRITE_CYCLES; PGM_FAIL models a failed write
// Overview of operation
// R1: Config read: opcode in, one latency cycle
// R2: Config data out falling edge, low byte first
// R3: Config repeats every sixteen clocks while selected; every four clocks in quad mode
// R4: Data lines ignored during latency cycle
// R5: Config program needs write enable latch set
// R6: Host sends two bytes, low byte first
// R7: Program only if CS rises after bit 16
// R8: WRITE_IN_PROGRESS high during write; clear WRITE_IN_PROGRESS, WRITE_ENABLE_LATCH after
// R9: Config program updates error and WRITE_IN_PROGRESS flags
// R10: Lock status read, latency, repeats every eight
// R11: Host reads lock status only when idle
// R12: Freeze clears volatile lock, copies secure bit
// R13: Freeze needs WRITE_ENABLE_LATCH and CS after bit 8
// R14: Password read: low byte first, MSB first
// R15: Password mode set: password read undefined
// R16: Password program needs WRITE_ENABLE_LATCH, ignored in mode
// R17: Password program: 64 bits then CS rise
// R18: Password program fail sets error, clears WRITE_ENABLE_LATCH
// R19: Unlock: 64 bits, CS rise, compare starts
// R20: Mismatch: error and WRITE_IN_PROGRESS stay until cleared
// R21: Match sets the volatile lock bit
// R22: Quad mode: all lines for everything
// R23: Write commands without WRITE_ENABLE_LATCH change nothing; password unlock here runs and sets the lock bit without it
module fpc_dev #(
   parameter int WRITE_CYC = fpc_pkg::WRITE_CYCLES
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   fpc_if.dev               LINK,
   input  wire logic        QUAD_MODE,
   input  wire logic        PGM_FAIL,
   output logic [7:0]       STATUS,
   output logic [15:0]      CFG,
   output logic [7:0]       LOCK
);
   typedef enum logic [1:0] {
      ST_CMD  = 2'b00,
      ST_DATA = 2'b01,
      ST_OUT  = 2'b10,
      ST_DONE = 2'b11
   } fpc_ph_t;
   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_CFG  = 2'b01,
      OP_PW   = 2'b10,
      OP_UNLK = 2'b11
   } fpc_op_t;

   // Synchronised link pins; reset to idle levels (CS high, SCK low, lines up)
   // so that no false SCK edge is seen after reset
   logic [5:0] pins_s;
   fpc_sync #(.W(6), .INIT(6'h2f)) u_sync (
      .CLK (CLK),
      .RSTN(RSTN),
      .D   ({LINK.cs_n, LINK.sck, LINK.io}),
      .Q   (pins_s)
   );
   wire       cs_n_s = pins_s[5];
   wire       sck_s  = pins_s[4];
   wire [3:0] io_s   = pins_s[3:0];

   logic        sck_d_r, cs_d_r;
   fpc_ph_t     ph_r;
   logic [7:0]  op_r;
   logic [6:0]  cnt_r;
   logic [63:0] sh_r;
   logic [63:0] out_r;
   logic [3:0]  dq_r;
   logic        oe_r;
   logic [15:0] cfg_r;
   logic [7:0]  lock_r;
   logic [63:0] pw_r;
   logic        wel_r, wip_r, perr_r, arm_r;
   fpc_op_t     job_r;
   logic [63:0] job_d_r;
   logic [15:0] tmr_r;
   logic        pend_r;

   wire rise    = sck_s & ~sck_d_r;
   wire fall    = ~sck_s & sck_d_r;
   wire cs_up   = cs_n_s & ~cs_d_r;
   wire [2:0] step = QUAD_MODE ? 3'd4 : 3'd1;        // [R22]
   wire [6:0] cmd_bits  = 7'd8;
   wire [7:0] op_now = QUAD_MODE ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]};
   wire pw_mode = ~cfg_r[fpc_pkg::CFG_PWMODE_BIT];
   wire is_rd   = (op_r == fpc_pkg::CMD_CFG_READ) | (op_r == fpc_pkg::CMD_LOCK_READ) |
                  (op_r == fpc_pkg::CMD_PW_READ)  | (op_r == fpc_pkg::CMD_STAT_READ);
   // Length of the repeating read word in bits
   wire [6:0] rd_len = (op_r == fpc_pkg::CMD_CFG_READ) ? 7'd16 :   // [R3]
                       (op_r == fpc_pkg::CMD_PW_READ)  ? 7'd64 : 7'd8;  // [R10] [R14]
   wire [6:0] wr_len = (op_r == fpc_pkg::CMD_CFG_PROG) ? 7'd16 : 7'd64;

   // Byte-swap so the low byte goes first, MSB first in each byte
   function automatic logic [63:0] lo_first(input logic [63:0] v, input int nb);
      logic [63:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         if (i < nb) r[63-8*i -: 8] = v[8*i +: 8];
      end
      return r;
   endfunction

   // Read word load; password hidden once password mode is chosen
   wire [63:0] rd_word =
      (op_r == fpc_pkg::CMD_CFG_READ)  ? lo_first({48'h0, cfg_r}, 2) :          // [R2]
      (op_r == fpc_pkg::CMD_LOCK_READ) ? {lock_r, 56'h0} :
      (op_r == fpc_pkg::CMD_STAT_READ) ? {STATUS, 56'h0} :
      (pw_mode ? 64'h0 : lo_first(pw_r, 8));                                  // [R15]

   // Received write data back to register order
   wire [63:0] wr_val = (op_r == fpc_pkg::CMD_CFG_PROG) ?
                        {48'h0, sh_r[7:0], sh_r[15:8]} : lo_first(lo_first(sh_r, 8), 8);
   wire [63:0] pw_in = {sh_r[7:0], sh_r[15:8], sh_r[23:16], sh_r[31:24],
                        sh_r[39:32], sh_r[47:40], sh_r[55:48], sh_r[63:56]};

   // Frame decoder: shifting in on rising SCK, out on falling SCK
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sck_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
         ph_r    <= ST_CMD;
         op_r    <= 8'h00;
         cnt_r   <= 7'd0;
         sh_r    <= 64'h0;
         out_r   <= 64'h0;
         dq_r    <= 4'h0;
         oe_r    <= 1'b0;
      end else begin
         sck_d_r <= sck_s;
         cs_d_r  <= cs_n_s;
         if (cs_n_s) begin
            ph_r  <= ST_CMD;
            cnt_r <= 7'd0;
            oe_r  <= 1'b0;
         end else begin
            case (ph_r)
               ST_CMD: if (rise) begin
                  sh_r  <= {56'h0, op_now};
                  cnt_r <= cnt_r + 7'(step);
                  if (cnt_r + 7'(step) == cmd_bits) begin
                     op_r  <= op_now;
                     cnt_r <= 7'd0;
                     ph_r  <= ST_DATA;
                  end
               end
               ST_DATA: if (is_rd) begin
                  // Latency rise passes with io ignored
                  if (rise) ph_r <= ST_OUT;                                   // [R1] [R4]
               end else if (rise && cnt_r <= 7'd64) begin    // Overrun breaks length match
                  sh_r  <= QUAD_MODE ? {sh_r[59:0], io_s} : {sh_r[62:0], io_s[0]};
                  cnt_r <= cnt_r + 7'(step);                                  // [R6] [R17]
               end
               ST_OUT: if (fall) begin
                  if (cnt_r == 7'd0) begin
                     out_r <= rd_word << (QUAD_MODE ? 4 : 1);
                     dq_r  <= QUAD_MODE ? rd_word[63:60] : {2'b00, rd_word[63], 1'b0};
                  end else begin
                     out_r <= out_r << (QUAD_MODE ? 4 : 1);
                     dq_r  <= QUAD_MODE ? out_r[63:60] : {2'b00, out_r[63], 1'b0};
                  end
                  oe_r  <= 1'b1;
                  cnt_r <= (cnt_r + 7'(step) >= rd_len) ? 7'd0 : cnt_r + 7'(step);
               end
               default: ph_r <= ST_CMD;
            endcase
         end
      end
   end

   // Decode of a completed frame at the CS rise
   wire cmd_done  = cs_up && ph_r == ST_DATA && cnt_r == 7'd0;
   wire data_done = cs_up && ph_r == ST_DATA && cnt_r == wr_len;
   wire go_write_enable_cmd   = cmd_done && op_r == fpc_pkg::CMD_WRITE_ENABLE_CMD && !wip_r;
   wire go_clr    = cmd_done && op_r == fpc_pkg::CMD_CLR_STAT;
   wire go_rst    = cmd_done && op_r == fpc_pkg::CMD_RST_GO && arm_r;
   wire go_cfg    = data_done && op_r == fpc_pkg::CMD_CFG_PROG && wel_r && !wip_r; // [R5] [R7]
   wire go_frz    = cmd_done && op_r == fpc_pkg::CMD_LOCK_FRZ && wel_r && !wip_r;  // [R13]
   wire go_pwp    = data_done && op_r == fpc_pkg::CMD_PW_PROG && wel_r && !wip_r
                    && !pw_mode;                                              // [R16] [R23]
   wire go_unlk   = data_done && op_r == fpc_pkg::CMD_PW_UNLOCK && !wip_r;     // [R19]

   // Register store and self-timed write engine
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cfg_r   <= fpc_pkg::CFG_RST;
         lock_r  <= fpc_pkg::LOCK_RST;
         pw_r    <= fpc_pkg::PW_RST;
         wel_r   <= 1'b0;
         wip_r   <= 1'b0;
         perr_r  <= 1'b0;
         arm_r   <= 1'b0;
         job_r   <= OP_NONE;
         job_d_r <= 64'h0;
         tmr_r   <= 16'h0;
         pend_r  <= 1'b0;
      end else begin
         if (cmd_done || data_done) arm_r <= (op_r == fpc_pkg::CMD_RST_ARM);
         if (go_write_enable_cmd) wel_r <= 1'b1;
         if (go_clr || go_rst) begin
            wip_r  <= 1'b0;                                                   // [R20]
            perr_r <= 1'b0;
            wel_r  <= 1'b0;
            pend_r <= 1'b0;
         end
         if (go_frz) begin
            lock_r[fpc_pkg::LOCK_VOL_BIT]  <= 1'b0;                           // [R12]
            lock_r[fpc_pkg::LOCK_SECR_BIT] <= cfg_r[fpc_pkg::CFG_SECR_BIT];
         end
         if (go_cfg || go_frz || go_pwp || go_unlk) begin
            wip_r   <= 1'b1;                                                  // [R8] [R9]
            pend_r  <= 1'b1;
            tmr_r   <= 16'(WRITE_CYC);
            job_r   <= go_cfg ? OP_CFG : go_pwp ? OP_PW : go_unlk ? OP_UNLK : OP_NONE;
            job_d_r <= go_cfg ? wr_val : pw_in;    // Held, later frames reuse the shifter
         end else if (pend_r) begin
            if (tmr_r > 16'd1) begin
               tmr_r <= tmr_r - 16'd1;
            end else begin
               pend_r <= 1'b0;
               case (job_r)
                  OP_UNLK: if (job_d_r == pw_r) begin
                     lock_r[fpc_pkg::LOCK_VOL_BIT] <= 1'b1;                   // [R21]
                     wip_r <= 1'b0;
                  end else begin
                     perr_r <= 1'b1;                                          // [R20]
                  end
                  OP_CFG: begin
                     if (PGM_FAIL) perr_r <= 1'b1;                            // [R9]
                     else cfg_r <= job_d_r[15:0];
                     wip_r <= 1'b0;
                     wel_r <= 1'b0;                                           // [R8]
                  end
                  OP_PW: begin
                     if (PGM_FAIL) perr_r <= 1'b1;                            // [R18]
                     else pw_r <= job_d_r;
                     wip_r <= 1'b0;
                     wel_r <= 1'b0;
                  end
                  default: begin
                     wip_r <= 1'b0;
                     wel_r <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   assign LINK.d_do = dq_r;
   assign LINK.d_oe = oe_r ? (QUAD_MODE ? 4'hf : 4'h2) : 4'h0;               // [R22]
   assign STATUS = {2'b00, perr_r, 3'b000, wel_r, wip_r};
   assign CFG    = cfg_r;
   assign LOCK   = lock_r;
endmodule

// [design/fpc_host.sv]
// Purpose: SPI host end issuing one protection command per request
// Assumes: Device samples on rising SCK, drives on falling SCK
// Notes:   SCK is made here by dividing CLK; read data taken just before falling SCK
module fpc_host #(
   parameter int HALF = fpc_pkg::SCK_HALF
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   fpc_if.host              LINK,
   input  wire logic        QUAD_MODE,
   input  wire logic        REQ,
   input  wire logic [7:0]  OPCODE,
   input  wire logic [6:0]  WR_BITS,
   input  wire logic [63:0] WR_DATA,
   input  wire logic [6:0]  RD_BITS,
   output logic             BUSY,
   output logic             DONE,
   output logic [63:0]      RD_DATA
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_RUN  = 2'b01,
      H_END  = 2'b10
   } fpc_hst_t;
   fpc_hst_t    st_r;
   logic [7:0]  div_r;
   logic        sck_r, cs_r, done_r;
   logic [7:0]  bit_r, total_r, rd_at_r;
   logic [71:0] tx_r;
   logic [63:0] rx_r;
   logic [3:0]  dq_r;

   wire [3:0] step = QUAD_MODE ? 4'd4 : 4'd1;
   wire       tick = (div_r == 8'(HALF - 1));
   wire [3:0] io_s;
   fpc_sync #(.W(4)) u_sync (.CLK(CLK), .RSTN(RSTN), .D(LINK.io), .Q(io_s));

   // Frame sequencer: data changes on falling SCK, total bits counted per rise
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_r <= H_IDLE; div_r <= 8'h0; sck_r <= 1'b0; cs_r <= 1'b1;
         bit_r <= 8'h0; total_r <= 8'h0; rd_at_r <= 8'h0; tx_r <= 72'h0;
         rx_r <= 64'h0; dq_r <= 4'h0; done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         case (st_r)
            H_IDLE: if (REQ) begin
               tx_r    <= {OPCODE, WR_DATA};                   // [R6] [R17] [R19]
               total_r <= 8'd8 + 8'(WR_BITS) + (RD_BITS != 0 ? 8'(fpc_pkg::LAT_CYCLES)
                          * 8'(step) : 8'd0) + 8'(RD_BITS);
               rd_at_r <= 8'd8 + 8'(fpc_pkg::LAT_CYCLES) * 8'(step);
               bit_r   <= 8'h0; cs_r <= 1'b0; div_r <= 8'h0;
               dq_r    <= QUAD_MODE ? OPCODE[7:4] : {3'b000, OPCODE[7]};
               st_r    <= H_RUN;
            end
            H_RUN: begin
               div_r <= tick ? 8'h0 : div_r + 8'h1;
               if (tick) begin
                  sck_r <= ~sck_r;
                  if (!sck_r) begin
                     bit_r <= bit_r + 8'(step);
                  end else begin
                     // Sampled late: sync stages on both ends delay the answer past the rise
                     if (bit_r > rd_at_r)
                        rx_r <= QUAD_MODE ? {rx_r[59:0], io_s} : {rx_r[62:0], io_s[1]};
                     tx_r <= QUAD_MODE ? tx_r << 4 : tx_r << 1;
                     dq_r <= QUAD_MODE ? tx_r[67:64] : {3'b000, tx_r[70]};
                     if (bit_r >= total_r) st_r <= H_END;   // [R7] [R13] CS right after last bit
                  end
               end
            end
            H_END: begin
               cs_r <= 1'b1; done_r <= 1'b1; st_r <= H_IDLE;
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   // The last write bit stands through its high phase, the device samples it late
   wire [7:0] wr_end  = 8'd8 + 8'(WR_BITS);
   wire       writing = (st_r == H_RUN) && !cs_r &&
                        (bit_r < wr_end || (sck_r && bit_r == wr_end));
   assign LINK.cs_n = cs_r;
   assign LINK.sck  = sck_r;
   assign LINK.h_do = dq_r;
   assign LINK.h_oe = writing ? (QUAD_MODE ? 4'hf : 4'h1) : 4'h0;      // [R4] float in latency
   assign BUSY    = (st_r != H_IDLE);
   assign DONE    = done_r;
   assign RD_DATA = rx_r;
endmodule

// [verification/fpc_props.sv]
// Purpose: Wire-level checks on the protection command link
// Assumes: Reads drive after 8 opcode rises (2 in quad) plus one latency rise
// Notes:   SCK is seen through CLK, so the device lags the wire by a few cycles
module fpc_props (
   input  wire logic       CLK,
   input  wire logic       RSTN,
   input  wire logic       QUAD_MODE,
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic [3:0] h_do,
   input  wire logic [3:0] h_oe,
   input  wire logic [3:0] d_do,
   input  wire logic [3:0] d_oe
);
   logic       sck_r;
   logic [7:0] rise_r;
   logic [7:0] rise_nxt;
   logic [7:0] lat_lim;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   // SCK rises in the frame; saturates so long reads cannot wrap
   assign rise_nxt = rise_r + {7'h00, sck & ~sck_r & (rise_r != 8'hff)};
   assign lat_lim  = QUAD_MODE ? 8'h03 : 8'h09;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sck_r  <= 1'b0;
         rise_r <= 8'h00;
      end else begin
         sck_r  <= sck;
         rise_r <= cs_n ? 8'h00 : rise_nxt;
      end
   end

   chk_no_contention: assert property ((h_oe & d_oe) == 4'h0)
      else $error("both ends drive a data line");
   chk_latency_quiet: assert property (!cs_n && rise_r != 8'h00 && rise_r < lat_lim
      |-> d_oe == 4'h0) else $error("device drives before latency ends");
   chk_dev_release: assert property (cs_n [*4] |-> d_oe == 4'h0)
      else $error("device drives while deselected");
   chk_sck_idle_low: assert property (cs_n [*2] |-> !sck)
      else $error("clock toggles outside a frame");
   chk_dout_falling: assert property (!cs_n && $changed(d_oe & d_do) |-> !sck)
      else $error("device data changes while clock high");
   chk_din_stable: assert property (!cs_n && $changed(h_oe & h_do) |-> !sck)
      else $error("host data changes while clock high");
   chk_single_host: assert property (!QUAD_MODE && h_oe != 4'h0 |-> h_oe == 4'h1)
      else $error("host uses extra lines in single mode");
   chk_single_dev: assert property (!QUAD_MODE && d_oe != 4'h0 |-> d_oe == 4'h2)
      else $error("device answers off the serial output");
   chk_quad_dev: assert property (QUAD_MODE && d_oe != 4'h0 |-> d_oe == 4'hf)
      else $error("device not on all lines in quad mode");
endmodule

// [verification/flash_protection_cmd_handler_tb.sv]
// Purpose: Self-checking bench joining host end and device end
// Assumes: WRITE_CYC shortened to 20 cycles, SCK half period 4 CLK
// Notes:   Read results are queued by the driver and checked on DONE
module flash_protection_cmd_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WCYC = 20;
   logic        clk, rstn, quad, pgm_fail, req, busy, done;
   logic [7:0]  opcode, status, lock, xlock;
   logic [6:0]  wr_bits, rd_bits;
   logic [63:0] wr_data, rd_data, pw, rd_mask;
   logic [15:0] cfg, cv;
   logic [70:0] note_q[$];
   logic [70:0] note;
   int          err_count, n_compared, cyc, seed;

   fpc_if u_fpc_if ();
   fpc_dev #(.WRITE_CYC(WCYC)) u_fpc_dev (.CLK(clk), .RSTN(rstn), .LINK(u_fpc_if.dev),
      .QUAD_MODE(quad), .PGM_FAIL(pgm_fail), .STATUS(status), .CFG(cfg), .LOCK(lock));
   fpc_host u_fpc_host (.CLK(clk), .RSTN(rstn), .LINK(u_fpc_if.host), .QUAD_MODE(quad),
      .REQ(req), .OPCODE(opcode), .WR_BITS(wr_bits), .WR_DATA(wr_data), .RD_BITS(rd_bits),
      .BUSY(busy), .DONE(done), .RD_DATA(rd_data));
   fpc_props u_fpc_props (.CLK(clk), .RSTN(rstn), .QUAD_MODE(quad), .cs_n(u_fpc_if.cs_n),
      .sck(u_fpc_if.sck), .h_do(u_fpc_if.h_do), .h_oe(u_fpc_if.h_oe),
      .d_do(u_fpc_if.d_do), .d_oe(u_fpc_if.d_oe));

   // 20 MHz clock
   always #25 clk = ~clk;

   // Byte order on the wire is low byte first, so words go out swapped
   function automatic logic [63:0] bsw(input logic [63:0] v);
      for (int i = 0; i < 8; i++)
         bsw[8*i +: 8] = v[56-8*i +: 8];
   endfunction

   task automatic check_val(input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t port exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic check_rd(input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t read exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One command; bus left idle 8 cycles after DONE so CS rise is seen
   task automatic cmd(input logic [7:0] op, input logic [6:0] wb, input logic [63:0] wd,
                      input logic [6:0] rb, input logic [63:0] exp);
      int n;
      note_q.push_back({rb, exp});
      opcode  <= op;
      wr_bits <= wb;
      wr_data <= wd;
      rd_bits <= rb;
      req     <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      check_val(64'h1, busy);
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (done !== 1'b1) begin
         err_count++;
         $display("[ERR] %0t command %h never finished", $time, op);
      end
      repeat (8) @(posedge clk);
      check_val(64'h0, busy);
   endtask

   task automatic op1(input logic [7:0] op);
      cmd(op, 7'h00, 64'h0, 7'h00, 64'h0);
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (status[0] !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (status[0] !== 1'b0) begin
         err_count++;
         $display("[ERR] %0t write never completed", $time);
      end
   endtask

   // Read results are compared as DONE appears, oldest note first
   always @(posedge clk) begin
      if (done === 1'b1) begin
         note = note_q.pop_front();
         rd_mask = ~(64'hffff_ffff_ffff_ffff << note[70:64]);
         if (note[70:64] != 7'h00)
            check_rd(note[63:0], rd_data & rd_mask);
      end
   end

   // Hang guard: generous for about thirty commands
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         finish_test();
      end
   end

   initial begin
      clk = 1'b0; rstn = 1'b0; quad = 1'b0; pgm_fail = 1'b0; req = 1'b0;
      opcode = 8'h00; wr_bits = 7'h00; wr_data = 64'h0; rd_bits = 7'h00;
      seed = 42874; err_count = 0; n_compared = 0; cyc = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      cv = 16'($random(seed));
      cv[2] = 1'b1;
      pw = {$random(seed), $random(seed)};
      cmd(fpc_pkg::CMD_CFG_READ, 7'h00, 64'h0, 7'h20,
          {2{fpc_pkg::CFG_RST[7:0], fpc_pkg::CFG_RST[15:8]}});
      cmd(fpc_pkg::CMD_LOCK_READ, 7'h00, 64'h0, 7'h10, {2{fpc_pkg::LOCK_RST}});
      $display("Test reset reads done");
      cmd(fpc_pkg::CMD_CFG_PROG, 7'h10, {cv[7:0], cv[15:8], 48'h0}, 7'h00, 64'h0);
      check_val(fpc_pkg::CFG_RST, cfg);
      check_val(8'h00, status);
      op1(fpc_pkg::CMD_WRITE_ENABLE_CMD);
      check_val(8'h02, status);
      cmd(fpc_pkg::CMD_CFG_PROG, 7'h10, {cv[7:0], cv[15:8], 48'h0}, 7'h00, 64'h0);
      check_val(8'h03, status);
      wait_idle();
      check_val(8'h00, status);
      check_val(cv, cfg);
      $display("Test config program done");
      pgm_fail <= 1'b1;
      op1(fpc_pkg::CMD_WRITE_ENABLE_CMD);
      cmd(fpc_pkg::CMD_PW_PROG, 7'h40, bsw(~pw), 7'h00, 64'h0);
      wait_idle();
      check_val(8'h20, status);
      pgm_fail <= 1'b0;
      op1(fpc_pkg::CMD_CLR_STAT);
      op1(fpc_pkg::CMD_WRITE_ENABLE_CMD);
      cmd(fpc_pkg::CMD_PW_PROG, 7'h40, bsw(pw), 7'h00, 64'h0);
      wait_idle();
      check_val(8'h00, status);
      cmd(fpc_pkg::CMD_PW_READ, 7'h00, 64'h0, 7'h40, bsw(pw));
      $display("Test password program done");
      quad <= 1'b1;
      op1(fpc_pkg::CMD_WRITE_ENABLE_CMD);
      cmd(fpc_pkg::CMD_CFG_PROG, 7'h08, {cv[7:0], 56'h0}, 7'h00, 64'h0);
      check_val(cv, cfg);
      check_val(8'h02, status);
      cmd(fpc_pkg::CMD_LOCK_FRZ, 7'h08, 64'h0, 7'h00, 64'h0);
      check_val(fpc_pkg::LOCK_RST, lock);
      cmd(fpc_pkg::CMD_CFG_READ, 7'h00, 64'h0, 7'h20, {2{cv[7:0], cv[15:8]}});
      op1(fpc_pkg::CMD_WRITE_ENABLE_CMD);
      op1(fpc_pkg::CMD_LOCK_FRZ);
      wait_idle();
      xlock = {fpc_pkg::LOCK_RST[7], cv[6], fpc_pkg::LOCK_RST[5:1], 1'b0};
      check_val(xlock, lock);
      cmd(fpc_pkg::CMD_LOCK_READ, 7'h00, 64'h0, 7'h08, {56'h0, xlock});
      quad <= 1'b0;
      $display("Test quad and freeze done");
      cmd(fpc_pkg::CMD_PW_UNLOCK, 7'h40, bsw(~pw), 7'h00, 64'h0);
      repeat (40) @(posedge clk);
      check_val(8'h21, status);
      cmd(fpc_pkg::CMD_STAT_READ, 7'h00, 64'h0, 7'h08, 64'h21);
      op1(fpc_pkg::CMD_CLR_STAT);
      check_val(8'h00, status);
      cmd(fpc_pkg::CMD_PW_UNLOCK, 7'h40, bsw(~pw), 7'h00, 64'h0);
      op1(fpc_pkg::CMD_RST_ARM);
      op1(fpc_pkg::CMD_RST_GO);
      check_val(8'h00, status);
      cmd(fpc_pkg::CMD_PW_UNLOCK, 7'h40, bsw(pw), 7'h00, 64'h0);
      wait_idle();
      check_val(xlock | 8'h01, lock);
      $display("Test unlock done");
      op1(fpc_pkg::CMD_WRITE_ENABLE_CMD);
      cmd(fpc_pkg::CMD_CFG_PROG, 7'h10, {cv[7:0] & 8'hfb, cv[15:8], 48'h0}, 7'h00, 64'h0);
      wait_idle();
      cmd(fpc_pkg::CMD_PW_READ, 7'h00, 64'h0, 7'h40, 64'h0);
      op1(fpc_pkg::CMD_WRITE_ENABLE_CMD);
      cmd(fpc_pkg::CMD_PW_PROG, 7'h40, bsw(~pw), 7'h00, 64'h0);
      check_val(8'h02, status);
      $display("Test password mode done");
      finish_test();
   end
endmodule
